// ### rtl/tpw_pkg.sv
package tpw_pkg;

  // ------------------------------------------------------------
  // Register word indices (byte address = index * 4)
  // ------------------------------------------------------------
  localparam logic [2:0] TPW_IDX_TIMER_CTRL = 3'h0;
  localparam logic [2:0] TPW_IDX_COUNTER = 3'h1;
  localparam logic [2:0] TPW_IDX_MODULO = 3'h2;
  localparam logic [2:0] TPW_IDX_CHAN0_CTRL = 3'h3;
  localparam logic [2:0] TPW_IDX_CHAN0_VALUE = 3'h4;
  localparam logic [2:0] TPW_IDX_CHAN1_CTRL = 3'h5;
  localparam logic [2:0] TPW_IDX_CHAN1_VALUE = 3'h6;
  localparam int TPW_ADR_LSB = 2;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int TPW_BIT_FLAG = 7;       // Overflow / channel event flag
  localparam int TPW_BIT_IRQ_EN = 6;     // Interrupt enable
  localparam int TPW_BIT_HALT = 5;       // Counter halt
  localparam int TPW_BIT_CLEAR = 4;      // Counter clear, write-only
  localparam int TPW_PS_MSB = 2;         // Prescaler select field 2:0
  localparam int TPW_CFG_MSB = 6;        // Channel config field 6:0

  // ------------------------------------------------------------
  // Widths, reset values and codes
  // ------------------------------------------------------------
  localparam int TPW_CNT_W = 16;
  localparam int TPW_DIV_W = 6;
  localparam int TPW_NCHAN = 2;
  localparam logic [15:0] TPW_MODULO_RST = 16'hffff;
  localparam logic [15:0] TPW_VALUE_RST = 16'h0000;
  localparam logic [2:0] TPW_PS_RST = 3'h0;
  localparam logic [2:0] TPW_PS_EXT = 3'h7;   // External timer clock pin
  localparam logic TPW_HALT_RST = 1'b1;

  // Channel control bits below the flag, in register order 6:0
  typedef struct packed {
    logic irq_en;
    logic ms_hi;        // Channel 0: channel_link_select
    logic ms_lo;        // mode_select_low
    logic els_hi;       // edge_level_high
    logic els_lo;       // edge_level_low
    logic tov;          // toggle_on_overflow
    logic max_duty;     // max_duty_bit
  } tpw_chan_cfg_t;

  localparam tpw_chan_cfg_t TPW_CFG_RST = '0;

  // Pin action on a compare
  typedef enum logic [1:0] {
    TPW_ACT_NONE,
    TPW_ACT_TOGGLE,
    TPW_ACT_CLEAR,
    TPW_ACT_SET
  } tpw_act_t;

endpackage

// ### rtl/tpw_chan.sv
`timescale 1ns/100ps
// Output stage of one compare channel
module tpw_chan
  import tpw_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire tpw_chan_cfg_t cfg_i,
  input wire logic release_i,
  input wire logic cmp_i,
  input wire logic ovf_i,
  // Pin
  output logic pin_o,
  output logic oe_n_o
);

  logic pin_q;
  logic pin_d;
  logic owns;
  logic full;
  tpw_act_t act;

  // ------------------------------------------------------------
  // Pin ownership and compare action decode
  // ------------------------------------------------------------
  assign owns = (cfg_i.ms_hi | cfg_i.ms_lo) & (cfg_i.els_hi | cfg_i.els_lo)
                & ~release_i;
  assign full = cfg_i.max_duty & cfg_i.tov;

  always_comb begin
    case ({cfg_i.els_hi, cfg_i.els_lo})
      2'b01: act = TPW_ACT_TOGGLE;
      2'b10: act = TPW_ACT_CLEAR;
      2'b11: act = TPW_ACT_SET;
      default: act = TPW_ACT_NONE;
    endcase
  end

  // ------------------------------------------------------------
  // Next pin level: compare action, then overflow toggle
  // ------------------------------------------------------------
  always_comb begin
    pin_d = pin_q;
    if (owns) begin
      if (cmp_i) begin
        case (act)
          TPW_ACT_TOGGLE: pin_d = ~pin_q;
          TPW_ACT_CLEAR: pin_d = 1'b0;
          TPW_ACT_SET: pin_d = 1'b1;
          default: pin_d = pin_q;
        endcase
      end
      // Without toggle the pin only settles where compares put it
      if (ovf_i && cfg_i.tov) begin
        pin_d = ~pin_d;
      end
      // Full duty holds the pulse level and masks every compare
      if (full) begin
        pin_d = ~cfg_i.els_lo;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign pin_o = pin_q;
  assign oe_n_o = ~owns;

endmodule // tpw_chan

// ### rtl/tpw_top.sv
`timescale 1ns/100ps
module tpw_top
  import tpw_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // External timer clock, synchronous to clk_i
  input wire logic ext_clk_i,
  // Channel pins, oe low while driven
  output logic [TPW_NCHAN-1:0] chan_pin_o,
  output logic [TPW_NCHAN-1:0] chan_oe_n_o,
  // Interrupt request levels
  output logic ovf_irq_o,
  output logic [TPW_NCHAN-1:0] chan_irq_o
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] mod_q, mod_d;
  logic [TPW_DIV_W-1:0] div_q, div_d;
  logic ext_q;
  logic halt_q, halt_d;
  logic ovf_ie_q, ovf_ie_d;
  logic [2:0] ps_q, ps_d;
  logic ovf_flag_q, ovf_flag_d;
  logic ovf_arm_q, ovf_arm_d;
  logic [15:0] val_q [TPW_NCHAN], val_d [TPW_NCHAN];
  tpw_chan_cfg_t cfg_q [TPW_NCHAN], cfg_d [TPW_NCHAN];
  logic [TPW_NCHAN-1:0] flag_q, flag_d;
  logic [TPW_NCHAN-1:0] arm_q, arm_d;
  logic sel1_q, sel1_d;
  logic pend1_q, pend1_d;
  logic [2:0] idx;
  logic wr_go, rd_go, link;
  logic tick, run, ovf;
  logic [TPW_DIV_W-1:0] mask;
  logic [15:0] val_used [TPW_NCHAN];
  logic [TPW_NCHAN-1:0] match, chan_evt, rel;
  tpw_chan_cfg_t cfg_eff [TPW_NCHAN];
  logic [31:0] rdata;
  logic clr_req;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // A write takes effect at the edge where the master sees ack
  assign idx = adr_i[TPW_ADR_LSB+:3];
  assign wr_go = cyc_i & stb_i & ack_q & we_i;
  assign rd_go = cyc_i & stb_i & ack_q & ~we_i;
  assign clr_req = wr_go && idx == TPW_IDX_TIMER_CTRL && sel_i[0]
                   && dat_i[TPW_BIT_CLEAR];
  assign link = cfg_q[0].ms_hi;

  // ------------------------------------------------------------
  // Prescaler and timer tick
  // ------------------------------------------------------------
  // Divide by two to the prescaler code; code 7 follows the pin
  assign mask = TPW_DIV_W'((7'h01 << ps_q) - 7'h01);
  assign tick = (ps_q == TPW_PS_EXT) ? (ext_clk_i & ~ext_q)
                                     : ((div_q & mask) == mask);
  assign run = tick & ~halt_q;
  assign ovf = run & (cnt_q == mod_q);

  // ------------------------------------------------------------
  // Channel compare values and matches
  // ------------------------------------------------------------
  // Values are used straight from the register, no shadow stage
  assign val_used[0] = (link && sel1_q) ? val_q[1] : val_q[0];
  assign val_used[1] = val_q[1];

  // Equality only, so a value already passed waits a full period
  generate
    for (genvar i = 0; i < TPW_NCHAN; i++) begin : g_match
      assign match[i] = run & (cnt_q == val_used[i]);
    end
  endgenerate

  // Channel 1 goes dark and frees its pin while linked
  assign rel[0] = 1'b0;
  assign rel[1] = link;

  // Link select wins over mode low on channel 0
  always_comb begin
    cfg_eff[0] = cfg_q[0];
    cfg_eff[1] = cfg_q[1];
    cfg_eff[1].ms_hi = 1'b0;
    if (link) begin
      cfg_eff[0].ms_lo = 1'b0;
    end
  end

  assign chan_evt[0] = match[0] & (cfg_eff[0].ms_hi | cfg_eff[0].ms_lo);
  assign chan_evt[1] = match[1] & cfg_eff[1].ms_lo & ~link;

  // ------------------------------------------------------------
  // Timer control, counter and flags: next state
  // ------------------------------------------------------------
  always_comb begin
    div_d = div_q + TPW_DIV_W'(1);
    cnt_d = cnt_q;
    mod_d = mod_q;
    halt_d = halt_q;
    ovf_ie_d = ovf_ie_q;
    ps_d = ps_q;
    ovf_flag_d = ovf_flag_q;
    ovf_arm_d = ovf_arm_q;
    if (run) begin
      cnt_d = ovf ? 16'h0000 : cnt_q + 16'h0001;
    end
    if (rd_go && idx == TPW_IDX_TIMER_CTRL && ovf_flag_q) begin
      ovf_arm_d = 1'b1;
    end
    if (wr_go && idx == TPW_IDX_MODULO) begin
      mod_d = merge16(mod_q, dat_i, sel_i);
    end
    if (wr_go && idx == TPW_IDX_TIMER_CTRL && sel_i[0]) begin
      ovf_ie_d = dat_i[TPW_BIT_IRQ_EN];
      halt_d = dat_i[TPW_BIT_HALT];
      ps_d = dat_i[TPW_PS_MSB:0];
      if (ovf_arm_q && !dat_i[TPW_BIT_FLAG]) begin
        ovf_flag_d = 1'b0;
      end
      ovf_arm_d = 1'b0;
    end
    // Clear bit restarts counting from zero and is never stored
    if (clr_req) begin
      cnt_d = 16'h0000;
      div_d = '0;
    end
    // A new overflow beats a clear in the same cycle
    if (ovf) begin
      ovf_flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= '0;
      ext_q <= 1'b0;
      cnt_q <= 16'h0000;
      mod_q <= TPW_MODULO_RST;
      halt_q <= TPW_HALT_RST;
      ovf_ie_q <= 1'b0;
      ps_q <= TPW_PS_RST;
      ovf_flag_q <= 1'b0;
      ovf_arm_q <= 1'b0;
    end else begin
      div_q <= div_d;
      ext_q <= ext_clk_i;
      cnt_q <= cnt_d;
      mod_q <= mod_d;
      halt_q <= halt_d;
      ovf_ie_q <= ovf_ie_d;
      ps_q <= ps_d;
      ovf_flag_q <= ovf_flag_d;
      ovf_arm_q <= ovf_arm_d;
    end
  end

  // ------------------------------------------------------------
  // Channel registers, flags and linked set select: next state
  // ------------------------------------------------------------
  always_comb begin
    sel1_d = sel1_q;
    pend1_d = pend1_q;
    for (int i = 0; i < TPW_NCHAN; i++) begin
      val_d[i] = val_q[i];
      cfg_d[i] = cfg_q[i];
      flag_d[i] = flag_q[i];
      arm_d[i] = arm_q[i];
    end
    for (int i = 0; i < TPW_NCHAN; i++) begin
      if (rd_go && idx == (i[0] ? TPW_IDX_CHAN1_CTRL : TPW_IDX_CHAN0_CTRL)
          && flag_q[i]) begin
        arm_d[i] = 1'b1;
      end
      if (wr_go && idx == (i[0] ? TPW_IDX_CHAN1_VALUE : TPW_IDX_CHAN0_VALUE))
      begin
        val_d[i] = merge16(val_q[i], dat_i, sel_i);
      end
      if (wr_go && sel_i[0]
          && idx == (i[0] ? TPW_IDX_CHAN1_CTRL : TPW_IDX_CHAN0_CTRL)) begin
        cfg_d[i] = tpw_chan_cfg_t'(dat_i[TPW_CFG_MSB:0]);
        if (arm_q[i] && !dat_i[TPW_BIT_FLAG]) begin
          flag_d[i] = 1'b0;
        end
        arm_d[i] = 1'b0;
      end
      // An event beats a clear in the same cycle
      if (chan_evt[i]) begin
        flag_d[i] = 1'b1;
      end
    end
    // Channel 1 has no link select of its own
    cfg_d[1].ms_hi = 1'b0;
    // Remember which set was written last
    if (wr_go && idx == TPW_IDX_CHAN1_VALUE) begin
      pend1_d = 1'b1;
    end else if (wr_go && idx == TPW_IDX_CHAN0_VALUE) begin
      pend1_d = 1'b0;
    end
    // Hand over only at a period boundary to avoid a torn pulse
    if (!link) begin
      sel1_d = 1'b0;
      pend1_d = 1'b0;
    end else if (ovf) begin
      sel1_d = pend1_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < TPW_NCHAN; i++) begin
        val_q[i] <= TPW_VALUE_RST;
        cfg_q[i] <= TPW_CFG_RST;
      end
      flag_q <= '0;
      arm_q <= '0;
      sel1_q <= 1'b0;
      pend1_q <= 1'b0;
    end else begin
      for (int i = 0; i < TPW_NCHAN; i++) begin
        val_q[i] <= val_d[i];
        cfg_q[i] <= cfg_d[i];
      end
      flag_q <= flag_d;
      arm_q <= arm_d;
      sel1_q <= sel1_d;
      pend1_q <= pend1_d;
    end
  end

  // ------------------------------------------------------------
  // Channel output stages
  // ------------------------------------------------------------
  generate
    for (genvar i = 0; i < TPW_NCHAN; i++) begin : g_chan
      tpw_chan u_chan (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cfg_i(cfg_eff[i]),
        .release_i(rel[i]),
        .cmp_i(match[i]),
        .ovf_i(ovf),
        .pin_o(chan_pin_o[i]),
        .oe_n_o(chan_oe_n_o[i])
      );
      assign chan_irq_o[i] = flag_q[i] & cfg_q[i].irq_en & ~rel[i];
    end
  endgenerate

  assign ovf_irq_o = ovf_flag_q & ovf_ie_q;

  // ------------------------------------------------------------
  // Read mux and bus answer
  // ------------------------------------------------------------
  // Unmapped words read as zero and still get an ack
  always_comb begin
    rdata = 32'h0000_0000;
    case (idx)
      TPW_IDX_TIMER_CTRL: begin
        rdata[TPW_BIT_FLAG] = ovf_flag_q;
        rdata[TPW_BIT_IRQ_EN] = ovf_ie_q;
        rdata[TPW_BIT_HALT] = halt_q;
        rdata[TPW_PS_MSB:0] = ps_q; // clear bit reads 0
      end
      TPW_IDX_COUNTER: rdata[15:0] = cnt_q;
      TPW_IDX_MODULO: rdata[15:0] = mod_q;
      TPW_IDX_CHAN0_CTRL: rdata[7:0] = {flag_q[0], cfg_q[0]};
      TPW_IDX_CHAN0_VALUE: rdata[15:0] = val_q[0];
      TPW_IDX_CHAN1_CTRL: rdata[7:0] = {flag_q[1], cfg_q[1]};
      TPW_IDX_CHAN1_VALUE: rdata[15:0] = val_q[1];
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_comb begin
    ack_d = cyc_i & stb_i & ~ack_q;
    dat_d = (cyc_i & stb_i & ~ack_q) ? rdata : dat_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

endmodule // tpw_top

// ### tb/tpw_checker.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port-level checker for the timer block
// ----------------------------------------
module tpw_checker
  import tpw_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Pins and requests
  input wire logic [TPW_NCHAN-1:0] chan_pin_o,
  input wire logic [TPW_NCHAN-1:0] chan_oe_n_o,
  input wire logic ovf_irq_o,
  input wire logic [TPW_NCHAN-1:0] chan_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic wr_ack;
  tpw_chan_cfg_t cfg0_q, cfg0_d;
  logic toie_q, toie_d;

  // Shadow of the written control bits, taken at the acked edge
  assign wr_ack = cyc_i & stb_i & we_i & ack_o & sel_i[0];
  always_comb begin
    cfg0_d = cfg0_q;
    toie_d = toie_q;
    if (wr_ack && adr_i[4:2] == TPW_IDX_CHAN0_CTRL) begin
      cfg0_d = tpw_chan_cfg_t'(dat_i[6:0]);
    end
    if (wr_ack && adr_i[4:2] == TPW_IDX_TIMER_CTRL) toie_d = dat_i[6];
  end
  always_ff @(posedge clk_i) begin
    cfg0_q <= rst_i ? TPW_CFG_RST : cfg0_d;
    toie_q <= rst_i ? 1'b0 : toie_d;
  end

  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_rd(logic [2:0] idx);
    cyc_i && stb_i && !ack_o && !we_i && adr_i[4:2] == idx ##1 ack_o;
  endsequence

  property p_ack_next;
    s_req |=> ack_o;
  endproperty
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  property p_clr_rd0;
    s_rd(TPW_IDX_TIMER_CTRL) |-> !dat_o[TPW_BIT_CLEAR];
  endproperty
  property p_link_rd0;
    s_rd(TPW_IDX_CHAN1_CTRL) |-> !dat_o[5];
  endproperty
  property p_unmap;
    s_rd(3'h7) |-> dat_o == 32'h0;
  endproperty
  property p_link_rel;
    cfg0_q.ms_hi |-> chan_oe_n_o[1] && !chan_irq_o[1];
  endproperty
  property p_max;
    cfg0_q.max_duty && cfg0_q.tov && $stable(cfg0_q)
      |-> chan_pin_o[0] == !cfg0_q.els_lo;
  endproperty
  property p_zero;
    !cfg0_q.tov && cfg0_q.els_hi && !cfg0_q.els_lo && $stable(cfg0_q)
      && !$past(chan_pin_o[0]) |-> !chan_pin_o[0];
  endproperty
  property p_ch_irq;
    chan_irq_o[0] |-> cfg0_q.irq_en;
  endproperty
  property p_ovf_irq;
    ovf_irq_o |-> toie_q;
  endproperty

  a_ack_next: assert property (p_ack_next)
    else $error("ack late");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack too long");
  a_clr_rd0: assert property (p_clr_rd0)
    else $error("clear bit reads one");
  a_link_rd0: assert property (p_link_rd0)
    else $error("chan1 link bit reads one");
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  a_link_rel: assert property (p_link_rel)
    else $error("pin1 held while linked");
  a_max: assert property (p_max)
    else $error("full duty level wrong");
  a_zero: assert property (p_zero)
    else $error("zero duty pin rose");
  a_ch_irq: assert property (p_ch_irq)
    else $error("channel request while disabled");
  a_ovf_irq: assert property (p_ovf_irq)
    else $error("overflow request while disabled");
endmodule // tpw_checker

bind tpw_top tpw_checker chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .chan_pin_o(chan_pin_o),
  .chan_oe_n_o(chan_oe_n_o), .ovf_irq_o(ovf_irq_o),
  .chan_irq_o(chan_irq_o)
);

// ### tb/tpw_load.sv
`timescale 1ns/100ps
// ----------------------------------------
// Load on the channel 0 pin: measures pulses
// ----------------------------------------
module tpw_load (
  // Clock
  input wire logic clk_i,
  // Pin from the device
  input wire logic pin_i,
  input wire logic oe_n_i,
  // Measurements
  output logic lvl_o,
  output logic [15:0] hi_len_o,
  output logic [15:0] per_len_o
);
  logic [15:0] hi_q;
  logic [15:0] per_q;
  logic last_q;

  // Pull-down: a released line reads low, never the last driven level
  assign lvl_o = oe_n_i ? 1'b0 : pin_i;

  // High time counted per sample; period counted rise to rise
  always_ff @(posedge clk_i) begin
    last_q <= lvl_o;
    hi_q <= lvl_o ? hi_q + 16'h1 : 16'h0;
    per_q <= (lvl_o && !last_q) ? 16'h1 : per_q + 16'h1;
    if (last_q && !lvl_o) hi_len_o <= hi_q;
    if (lvl_o && !last_q) per_len_o <= per_q;
  end
endmodule // tpw_load

// ### tb/tpw_bench.sv
`timescale 1ns/100ps
module tpw_bench
  import tpw_pkg::*;
;
  typedef struct packed {
    logic [2:0] idx;
    logic [31:0] exp;
  } tpw_row_t;
  // ----------------------------------------
  // Reset values, one row per word index, unmapped index 7 included
  // ----------------------------------------
  localparam tpw_row_t ROWS [8] = '{'{3'h0, 32'h20}, '{3'h1, 32'h0},
    '{3'h2, 32'hffff}, '{3'h3, 32'h0}, '{3'h4, 32'h0}, '{3'h5, 32'h0},
    '{3'h6, 32'h0}, '{3'h7, 32'h0}};
  localparam logic [31:0] MOD = 32'hff;

  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, ovf_irq_o, lvl;
  logic [4:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [1:0] chan_pin_o, chan_oe_n_o, chan_irq_o;
  logic [15:0] hi_len, per_len;
  int fail_count, samples_checked;

  tpw_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ext_clk_i(1'b0),
    .chan_pin_o(chan_pin_o), .chan_oe_n_o(chan_oe_n_o),
    .ovf_irq_o(ovf_irq_o), .chan_irq_o(chan_irq_o));
  tpw_load load_u (.clk_i(clk_i), .pin_i(chan_pin_o[0]),
    .oe_n_i(chan_oe_n_o[0]), .lvl_o(lvl), .hi_len_o(hi_len),
    .per_len_o(per_len));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle; the wait is bounded, a lost ack counts as a miss
  task wb(input logic w, input logic [2:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    chk(32'(ack_o), 32'h1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task hold(input logic exp);
    repeat (12) begin
      @(posedge clk_i);
      chk(32'(lvl), 32'(exp));
    end
  endtask

  task wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog, several times the expected run
  initial begin
    #2000000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    {rst_i, cyc_i, stb_i, we_i} = 4'h8;
    {adr_i, dat_i} = '0;
    sel_i = 4'h3;
    fail_count = 0;
    samples_checked = 0;
    wt(20);
    rst_i <= 1'b0;
    foreach (ROWS[i]) begin
      wb(1'b0, ROWS[i].idx, 32'h0);
      chk(rd, ROWS[i].exp);
    end
    $display("test reset done");
    wb(1'b1, 3'h0, 32'h30);
    wb(1'b0, 3'h1, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 3'h2, MOD);
    wb(1'b1, 3'h4, 32'h80);
    wb(1'b1, 3'h3, 32'h1a);
    wb(1'b1, 3'h0, 32'h0);
    wt(800);
    chk(per_len, MOD + 1);
    chk(hi_len, 32'h81);
    chk(chan_oe_n_o, 2'b10);
    // Shorter pulse written just after the compare has ended the pulse
    @(negedge lvl);
    wb(1'b1, 3'h4, 32'h40);
    wt(800);
    chk(hi_len, 32'h41);
    // Longer pulse written just after the overflow has started the pulse
    @(posedge lvl);
    wb(1'b1, 3'h4, 32'h60);
    wt(800);
    chk(hi_len, 32'h61);
    wb(1'b1, 3'h3, 32'h1e);
    wt(800);
    chk(hi_len, MOD - 32'h60);
    $display("test pwm done");
    wb(1'b1, 3'h3, 32'h1b);
    wt(300);
    hold(1'b1);
    wb(1'b1, 3'h3, 32'h18);
    wt(300);
    hold(1'b0);
    $display("test duty limits done");
    wb(1'b1, 3'h0, 32'h40);
    wb(1'b1, 3'h3, 32'h5a);
    wt(300);
    chk(chan_irq_o, 2'b01);
    chk(ovf_irq_o, 1'b1);
    wb(1'b1, 3'h0, 32'h60);
    wb(1'b0, 3'h3, 32'h0);
    chk(rd, 32'hda);
    // Enable stays on, so a quiet request proves the flag really cleared
    wb(1'b1, 3'h3, 32'h5a);
    wb(1'b0, 3'h0, 32'h0);
    chk(rd, 32'he0);
    wb(1'b1, 3'h0, 32'h60);
    @(posedge clk_i);
    chk(chan_irq_o, 2'b00);
    chk(ovf_irq_o, 1'b0);
    wb(1'b1, 3'h0, 32'h0);
    $display("test requests done");
    wb(1'b1, 3'h4, 32'h20);
    wb(1'b1, 3'h5, 32'h1e);
    wb(1'b1, 3'h3, 32'h3a);
    wt(800);
    chk(hi_len, 32'h21);
    chk(chan_oe_n_o, 2'b10);
    wb(1'b1, 3'h6, 32'h60);
    wt(800);
    chk(hi_len, 32'h61);
    wb(1'b1, 3'h4, 32'h10);
    wt(800);
    chk(hi_len, 32'h11);
    wb(1'b0, 3'h5, 32'h0);
    chk(rd & 32'h7f, 32'h1e);
    // Unlinking hands pin 1 back; full duty shows on it at once
    wb(1'b1, 3'h5, 32'h1b);
    wb(1'b1, 3'h3, 32'h1a);
    wt(2);
    chk(chan_oe_n_o, 2'b00);
    chk(32'(chan_pin_o[1]), 32'h1);
    $display("test linked done");
    report_and_stop();
  end
endmodule // tpw_bench
